// [inc/snzsc_pkg.sv]
// Purpose: constants and types shared by the snooze state controller
// Assumes: single clock domain, clk_sys at 250 MHz
// Notes: condition and release-source selects are plain input vectors
//
// Overview of operation
// - snooze entry restarts previously running oscillators
// - peripheral clock gated until oscillators stable
// - end-of-activity interrupt wakes to normal
// - no wake, no end: stay in snooze
// - end condition returns to standby, CPU halted
// - back in standby: stop restarted oscillators, peripheral
// - CPU stays halted throughout snooze
// - low-power timer runs in standby, triggers snooze
// - serial reception proceeds during snooze
// - transfer controller may run during snooze
// - no selected entry condition keeps standby
// - selected release source raises release interrupt, wakes
// - release interrupt fires outside snooze too
package snzsc_pkg;
   localparam int unsigned NUM_SRC  = 4;
   localparam int unsigned NUM_OSC  = 4;
   // source bit positions, shared by entry, end and release selects
   localparam int unsigned SRC_SERIAL = 0;
   localparam int unsigned SRC_TIMER  = 1;
   localparam int unsigned SRC_CONV   = 2;
   localparam int unsigned SRC_TOUCH  = 3;
   localparam logic [NUM_OSC-1:0] OSC_RESET = 4'h1;

   typedef enum logic [2:0] {
      SNZSC_NORMAL,
      SNZSC_STANDBY,
      SNZSC_OSC_WAIT,
      SNZSC_SNOOZE
   } snzsc_state_t;
endpackage

// [core/snzsc_edge.sv]
// Purpose: rising-edge detector for a vector of event levels
// Assumes: inputs synchronous to clk_sys
// Notes: one-cycle pulse per rising edge on each bit
`timescale 1ns/100ps
module snzsc_edge #(
   parameter int unsigned WIDTH = 4
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [WIDTH-1:0] level_in,
   output logic      [WIDTH-1:0] pulse_out
);
   typedef struct packed {
      logic [WIDTH-1:0] prev;
   } snzsc_edge_t;

   snzsc_edge_t cur;
   snzsc_edge_t next_cur;

   always_comb begin
      next_cur.prev = level_in;
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   assign pulse_out = level_in & ~cur.prev;
endmodule

// [core/snzsc_ctrl.sv]
// Purpose: power-state controller for standby / snooze / normal
// Assumes: event inputs are levels synchronous to clk_sys; sleep_req is a pulse
// Notes: peripheral events are edge detected; select vectors are held static by software
`timescale 1ns/100ps
module snzsc_ctrl #(
   parameter int unsigned NSRC = snzsc_pkg::NUM_SRC,
   parameter int unsigned NOSC = snzsc_pkg::NUM_OSC
) (
   input  wire logic                clk_sys,
   input  wire logic                sys_rst,
   input  wire logic                sleep_req,
   input  wire logic                wake_irq,
   input  wire logic [NSRC-1:0]     snz_entry_sel,
   input  wire logic [NSRC-1:0]     snz_end_sel,
   input  wire logic [NSRC-1:0]     snooze_release_source_select,
   input  wire logic [NSRC-1:0]     entry_event,
   input  wire logic [NSRC-1:0]     end_event,
   input  wire logic [NSRC-1:0]     release_event,
   input  wire logic [NOSC-1:0]     osc_running,
   input  wire logic [NOSC-1:0]     osc_stable,
   output logic      [NOSC-1:0]     osc_enable,
   output logic                     periph_clk_en,
   output logic                     cpu_halt,
   output logic                     low_power_timer_run,
   output logic                     async_serial_receiver_en,
   output logic                     transfer_controller_en,
   output logic                     snooze_release_irq,
   output logic      [1:0]          power_state
);
   typedef struct packed {
      snzsc_pkg::snzsc_state_t st;
      logic [NOSC-1:0]         saved_osc;
      logic [NOSC-1:0]         osc_en;
      logic                    pclk;
      logic                    halt;
      logic                    irq;
   } snzsc_ctrl_t;

   snzsc_ctrl_t     cur;
   snzsc_ctrl_t     next_cur;
   logic [NSRC-1:0] entry_p;
   logic [NSRC-1:0] end_p;
   logic [NSRC-1:0] rel_p;

   snzsc_edge #(.WIDTH(3*NSRC)) u_edge (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .level_in  ({release_event, end_event, entry_event}),
      .pulse_out ({rel_p, end_p, entry_p})
   );

   // power_state encoding seen by the outside world
   localparam logic [1:0] PS_NORMAL  = 2'h0;
   localparam logic [1:0] PS_STANDBY = 2'h1;
   localparam logic [1:0] PS_SNOOZE  = 2'h2;

   function automatic logic hit(input logic [NSRC-1:0] sel, input logic [NSRC-1:0] ev);
      hit = |(sel & ev);
   endfunction

   // only the oscillators that were restarted must report stable
   function automatic logic all_stable(input logic [NOSC-1:0] stable, input logic [NOSC-1:0] need);
      all_stable = ((stable & need) == need);
   endfunction

   always_comb begin
      next_cur     = cur;
      next_cur.irq = hit(snooze_release_source_select, rel_p);
      unique case (cur.st)
         snzsc_pkg::SNZSC_NORMAL: begin
            next_cur.halt = 1'b0;
            next_cur.pclk = 1'b1;
            if (sleep_req) begin
               // remember which oscillators ran so snooze can bring back exactly those
               next_cur.saved_osc = osc_running;
               next_cur.osc_en    = '0;
               next_cur.pclk      = 1'b0;
               next_cur.halt      = 1'b1;
               next_cur.st        = snzsc_pkg::SNZSC_STANDBY;
            end
         end
         snzsc_pkg::SNZSC_STANDBY: begin
            if (wake_irq) begin
               next_cur.osc_en = cur.saved_osc;
               next_cur.st     = snzsc_pkg::SNZSC_OSC_WAIT;
               next_cur.halt   = 1'b1;
            end else if (hit(snz_entry_sel, entry_p)) begin
               next_cur.osc_en = cur.saved_osc;
               next_cur.st     = snzsc_pkg::SNZSC_OSC_WAIT;
            end
         end
         snzsc_pkg::SNZSC_OSC_WAIT: begin
            // clock stays gated until every restarted oscillator is stable
            if (all_stable(osc_stable, cur.saved_osc)) begin
               next_cur.pclk = 1'b1;
               next_cur.st   = snzsc_pkg::SNZSC_SNOOZE;
            end
         end
         snzsc_pkg::SNZSC_SNOOZE: begin
            next_cur.halt = 1'b1;
            if (wake_irq || hit(snooze_release_source_select, rel_p)) begin
               next_cur.halt = 1'b0;
               next_cur.st   = snzsc_pkg::SNZSC_NORMAL;
            end else if (hit(snz_end_sel, end_p)) begin
               next_cur.osc_en = '0;
               next_cur.pclk   = 1'b0;
               next_cur.st     = snzsc_pkg::SNZSC_STANDBY;
            end
            // otherwise remain in snooze
         end
         default: begin
            next_cur.st = snzsc_pkg::SNZSC_NORMAL;
         end
      endcase
      // a wake from standby passes through osc wait, then leaves halt
      if (cur.st == snzsc_pkg::SNZSC_OSC_WAIT && wake_irq &&
          all_stable(osc_stable, cur.saved_osc)) begin
         next_cur.halt = 1'b0;
         next_cur.st   = snzsc_pkg::SNZSC_NORMAL;
      end
      if (next_cur.st == snzsc_pkg::SNZSC_NORMAL) begin
         next_cur.osc_en = {NOSC{1'b1}};
      end
   end

   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         cur.st        <= snzsc_pkg::SNZSC_NORMAL;
         cur.saved_osc <= snzsc_pkg::OSC_RESET;
         cur.osc_en    <= {NOSC{1'b1}};
         cur.pclk      <= 1'b1;
         cur.halt      <= 1'b0;
         cur.irq       <= 1'b0;
      end else begin
         cur <= next_cur;
      end
   end

   logic in_snooze;
   assign in_snooze                = (cur.st == snzsc_pkg::SNZSC_SNOOZE);
   assign osc_enable               = cur.osc_en;
   assign periph_clk_en            = cur.pclk;
   assign cpu_halt                 = cur.halt;
   assign snooze_release_irq       = cur.irq;
   // timer is on its own low-speed clock and never stops in standby
   assign low_power_timer_run      = 1'b1;
   assign async_serial_receiver_en = ~cur.halt | in_snooze;
   assign transfer_controller_en   = ~cur.halt | in_snooze;
   // oscillator wait reports as standby: the CPU is still halted there
   assign power_state              = (cur.st == snzsc_pkg::SNZSC_NORMAL)  ? PS_NORMAL :
                                     (cur.st == snzsc_pkg::SNZSC_SNOOZE)  ? PS_SNOOZE : PS_STANDBY;
endmodule

// [verif/snzsc_osc_model.sv]
// Purpose: oscillator bank behind the controller's enables
// Assumes: one oscillator per enable bit
// Notes: start-up time grows with the index so restarts finish in index order, one cycle apart
`timescale 1ns/100ps
module snzsc_osc_model (
   input  wire logic       clk_sys,
   input  wire logic [3:0] osc_enable,
   output logic      [3:0] osc_stable
);
   int cnt [4] = '{default: 0};
   initial osc_stable = 4'h0;
   always @(posedge clk_sys) begin
      for (int i = 0; i < 4; i++) begin
         cnt[i] = osc_enable[i] ? cnt[i] + 1 : 0;
         osc_stable[i] <= (cnt[i] > 2 + i); // a stopped oscillator loses stability at once
      end
   end
endmodule

// [verif/snzsc_ctrl_asserts.sv]
// Purpose: port checks for the snooze state controller
// Assumes: one clock, async active-high reset
// Notes: event edges rebuilt here, history cleared by reset as in the controller
`timescale 1ns/100ps
module snzsc_ctrl_asserts (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       sleep_req,
   input wire logic       wake_irq,
   input wire logic [3:0] snz_entry_sel,
   input wire logic [3:0] snz_end_sel,
   input wire logic [3:0] snooze_release_source_select,
   input wire logic [3:0] entry_event,
   input wire logic [3:0] end_event,
   input wire logic [3:0] release_event,
   input wire logic [3:0] osc_enable,
   input wire logic       periph_clk_en,
   input wire logic       cpu_halt,
   input wire logic       snooze_release_irq,
   input wire logic [1:0] power_state
);
   logic [11:0] prv;
   wire [3:0] ent = entry_event & ~prv[11:8] & snz_entry_sel;
   wire [3:0] fin = end_event & ~prv[7:4] & snz_end_sel;
   wire [3:0] rel = release_event & ~prv[3:0] & snooze_release_source_select;
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         prv <= 12'h000;
      end else begin
         prv <= {entry_event, end_event, release_event};
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   chk_sleep_enter: assert property (power_state == 2'h0 && sleep_req |=> power_state == 2'h1 && cpu_halt)
      else $error("sleep request missed standby");
   chk_from_standby: assert property ($rose(power_state == 2'h2) |-> $past(power_state) == 2'h1)
      else $error("snooze entered from wrong state");
   chk_snooze_halt: assert property (power_state == 2'h2 |-> cpu_halt)
      else $error("cpu ran in snooze");
   chk_entry_nosel: assert property (power_state == 2'h1 && snz_entry_sel == 4'h0 && !wake_irq |=> power_state == 2'h1)
      else $error("left standby without entry select");
   chk_entry_osc: assert property (power_state == 2'h1 && (|ent) |=> osc_enable != 4'h0 && !periph_clk_en)
      else $error("entry did not restart oscillators");
   chk_end_standby: assert property (power_state == 2'h2 && (|fin) && rel == 4'h0 && !wake_irq |=>
      power_state == 2'h1 && cpu_halt && osc_enable == 4'h0 && !periph_clk_en)
      else $error("end condition mishandled");
   chk_release_irq: assert property ((|rel) |=> snooze_release_irq ##1 !snooze_release_irq)
      else $error("release irq not one pulse");
   chk_release_wake: assert property (power_state == 2'h2 && (|rel) |=> power_state == 2'h0 && !cpu_halt)
      else $error("release did not wake");
   cover property (power_state == 2'h2 && (|fin));
   cover property (power_state == 2'h2 && (|rel));
   cover property (power_state == 2'h0 && (|rel));
   cover property (power_state == 2'h1 && wake_irq ##1 power_state == 2'h1 && cpu_halt);
endmodule
bind snzsc_ctrl snzsc_ctrl_asserts chk_u (.*);

// [verif/tb.sv]
// Purpose: self-checking bench for the snooze state controller
// Assumes: oscillator model answers restarts after a short start-up
// Notes: wake_irq is raised only for the final wake from standby, so only release sources wake from snooze
`timescale 1ns/100ps
module tb;
   logic clk_sys = 1'b0, sys_rst = 1'b1, sleep_req = 1'b0, wake_irq = 1'b0;
   logic [3:0] snz_entry_sel = 4'h0, snz_end_sel = 4'h0, snooze_release_source_select = 4'h0;
   logic [3:0] entry_event = 4'h0, end_event = 4'h0, release_event = 4'h0, osc_running = 4'h1;
   logic [3:0] osc_stable, osc_enable;
   logic periph_clk_en, cpu_halt, low_power_timer_run, async_serial_receiver_en;
   logic transfer_controller_en, snooze_release_irq;
   logic [1:0] power_state;
   int err_count = 0, n_tests = 0, cycles = 0;
   snzsc_ctrl dut_u (.*);
   snzsc_osc_model osc_u (.*);
   always #2 clk_sys = ~clk_sys;
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic step; @(negedge clk_sys); endtask
   // level stays high for one clock so the controller sees exactly one edge
   task automatic hit(ref logic [3:0] ev, input int b);
      ev[b] = 1'b1;
      step;
      ev = 4'h0;
   endtask
   task automatic to_snooze;
      for (int k = 0; k < 40 && power_state !== 2'h2; k++) step;
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         finish_test;
      end
   end
   initial begin
      void'($urandom(97));
      repeat (10) step;
      sys_rst = 1'b0;
      cmp({power_state, cpu_halt, periph_clk_en, osc_enable}, 8'h1f);
      for (int i = 0; i < 4; i++) begin
         osc_running = 4'($urandom_range(15, 1));
         sleep_req = 1'b1;
         step;
         sleep_req = 1'b0;
         snz_entry_sel = 4'h0;
         hit(entry_event, i);
         repeat (10) step;
         cmp({power_state, cpu_halt, low_power_timer_run}, 3'h7);
         snz_entry_sel = 4'h1 << i;
         snz_end_sel = 4'h1 << i;
         hit(entry_event, i);
         cmp({power_state, periph_clk_en, osc_enable}, {3'h2, osc_running});
         to_snooze;
         cmp({osc_stable & osc_running, power_state, cpu_halt, periph_clk_en}, {osc_running, 4'hb});
         cmp({async_serial_receiver_en, transfer_controller_en, low_power_timer_run}, 3'h7);
         hit(end_event, (i + 1) % 4);
         repeat (4) step;
         cmp(power_state, 2'h2);
         if (i % 2 == 0) begin
            hit(end_event, i);
            cmp({power_state, cpu_halt, periph_clk_en, osc_enable}, 8'h60);
            hit(entry_event, i);
            to_snooze;
         end
         snooze_release_source_select = 4'h1 << i;
         hit(release_event, i);
         cmp({snooze_release_irq, power_state, cpu_halt, osc_enable}, 8'h8f);
         step;
         cmp(snooze_release_irq, 1'b0);
      end
      // ordinary wake from standby: halt holds until the oscillators are back
      sleep_req = 1'b1;
      step;
      sleep_req = 1'b0;
      wake_irq = 1'b1;
      step;
      cmp({power_state, cpu_halt}, 3'h3);
      for (int k = 0; k < 40 && power_state !== 2'h0; k++) step;
      wake_irq = 1'b0;
      cmp({power_state, cpu_halt, osc_enable}, 7'h0f);
      hit(release_event, 3);
      cmp({snooze_release_irq, power_state}, 3'h4);
      finish_test;
   end
endmodule
